// ===== logic/annp_pkg.sv
package annp_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] ANNP_OFF_EXP = 5'h06;
    localparam logic [4:0] ANNP_OFF_NPTX = 5'h07;
    localparam logic [4:0] ANNP_OFF_NPRX = 5'h08;
    localparam logic [4:0] ANNP_OFF_CFG1 = 5'h09;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] ANNP_RST_EXP = 16'h0064;
    localparam logic [15:0] ANNP_RST_NPTX = 16'h2001;
    localparam logic [15:0] ANNP_RST_NPRX = 16'h2001;
    localparam logic [15:0] ANNP_RST_CFG1 = 16'h0300;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ANNP_EXP_LOC_DEF = 6;
    localparam int ANNP_EXP_STORE = 5;
    localparam int ANNP_EXP_PDF = 4;
    localparam int ANNP_EXP_LP_NP = 3;
    localparam int ANNP_EXP_LOC_NP = 2;
    localparam int ANNP_EXP_PAGE = 1;
    localparam int ANNP_EXP_LP_AN = 0;
    localparam int ANNP_NP_MORE = 15;
    localparam int ANNP_NP_ACK = 14;
    localparam int ANNP_NP_MSG = 13;
    localparam int ANNP_NP_ACK2 = 12;
    localparam int ANNP_NP_TOG = 11;
    localparam int ANNP_NP_PAY_W = 11;
    localparam int ANNP_CFG_TM_LO = 13;
    localparam int ANNP_CFG_RF_EN = 12;
    localparam int ANNP_CFG_RF_VAL = 11;
    localparam int ANNP_CFG_PORT = 10;
    localparam int ANNP_CFG_GFD = 9;
    localparam int ANNP_CFG_GHD = 8;
    localparam int ANNP_CFG_TDR = 7;

    // Writable masks
    localparam logic [15:0] ANNP_NPTX_WMASK = 16'hb7ff;
    localparam logic [15:0] ANNP_CFG1_WMASK = 16'hff80;

    typedef enum logic [2:0] {
        ANNP_TM_NORMAL = 3'h0,
        ANNP_TM_WAVE = 3'h1,
        ANNP_TM_JIT_LEAD = 3'h2,
        ANNP_TM_JIT_FOLL = 3'h3,
        ANNP_TM_DIST = 3'h4,
        ANNP_TM_IDLES = 3'h5,
        ANNP_TM_0001 = 3'h6,
        ANNP_TM_PULSE63 = 3'h7
    } annp_test_mode_t;

    // Management access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [15:0] wdata;
    } annp_mgmt_req_t;

    // Engine status toward registers
    typedef struct packed {
        logic pd_fault;
        logic page_rx;
        logic partner_np_capable;
        logic lp_an_able;
        logic [15:0] rx_page;
        logic page_tx;
        logic adv_toggle;
        logic lp_base_toggle;
        logic an_restart;
        logic link_down;
    } annp_eng_t;

    // Configuration toward the engine
    typedef struct packed {
        annp_test_mode_t test_mode;
        logic role_force_enable;
        logic role_force_value;
        logic multi_port;
        logic gig_full_duplex_offer;
        logic gig_half_duplex_offer;
        logic reflectometry_on_link_loss;
    } annp_cfg_t;

endpackage

// ===== logic/annp_latch.sv
`timescale 1ns/1ps
`default_nettype none

// Latched-high status bit, set wins over read clear
module annp_latch (
    input wire logic clk, // Core clock
    input wire logic rst, // Sync reset
    input wire logic ce, // Clock enable
    input wire logic set, // Event pulse
    input wire logic clr, // Read of owning register
    output logic q // Latched level
);
    typedef struct packed {
        logic q_r;
    } annp_latch_st_t;

    annp_latch_st_t st_r;
    annp_latch_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (set) begin
            st_nxt.q_r = 1'b1; // RL22
        end else if (clr) begin
            st_nxt.q_r = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.q_r;
endmodule

`default_nettype wire

// ===== logic/annp_tdr_trig.sv
`timescale 1ns/1ps
`default_nettype none

// One-pulse cable test start on link loss when enabled
module annp_tdr_trig (
    input wire logic clk, // Core clock
    input wire logic rst, // Sync reset
    input wire logic ce, // Clock enable
    input wire logic enable, // Auto-run enabled
    input wire logic link_down, // Link-down event pulse
    input wire logic tdr_busy, // Reflectometry running
    output logic tdr_start // Start pulse
);
    typedef struct packed {
        logic pend_r;
        logic start_r;
    } annp_tdr_st_t;

    annp_tdr_st_t st_r;
    annp_tdr_st_t st_nxt;

    // Pending held so a link loss during a run already in progress is not lost
    always_comb begin
        st_nxt = st_r;
        st_nxt.start_r = 1'b0;
        if (link_down && enable) begin
            st_nxt.pend_r = 1'b1; // RL20
        end else if (!enable) begin
            st_nxt.pend_r = 1'b0;
        end
        // Enable rechecked so clearing bit 7 drops a waiting run
        if (st_r.pend_r && enable && !tdr_busy) begin
            st_nxt.start_r = 1'b1; // RL20
            st_nxt.pend_r = link_down && enable;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign tdr_start = st_r.start_r;
endmodule

`default_nettype wire

// ===== logic/annp_regs.sv
`timescale 1ns/1ps
`default_nettype none

//------------------------------------------------------------------
// Function
// RL1 - Expansion bit 6 reads 1: bit 5 defines received next-page location
// RL2 - Expansion bit 5 reads 1: partner next pages land at offset 8
// RL3 - Expansion bit 4 latches parallel-detect fault, clears on read
// RL4 - Expansion bit 3 shows partner next-page ability, read-only
// RL5 - Expansion bit 2 reads 1: local device supports next pages
// RL6 - Expansion bit 1 latches new page received, clears on read
// RL7 - Expansion bit 0 shows partner auto-negotiation ability, read-only
// RL8 - Transmit bit 15 more-pages flag, sent in next transmitted page
// RL9 - Transmit bit 13 message/unformatted page select, resets to 1
// RL10 - Transmit bit 12 drives transmitted ACK2 bit
// RL11 - Transmit bit 11 read-only toggle, starts inverse of advert bit 11
// RL12 - Transmit bits 10:0 payload, resets to 1
// RL13 - Receive register read-only; bit 15 more-pages, bit 14 acknowledge
// RL14 - Receive bit 13 message page, bit 12 partner ACK2
// RL15 - Receive bit 11 partner toggle, starts inverse of partner base bit 11
// RL16 - Config bits 15:13 select test mode, 0 normal, 1..7 tests
// RL17 - Config bit 12 forces role from bit 11, else negotiated
// RL18 - Config bit 10 port type: 0 single-port, 1 multi-port
// RL19 - Config bits 9,8 gigabit full/half duplex offer, strap defaults
// RL20 - Config bit 7 runs reflectometry automatically after link down
// RL21 - Expansion register at offset 6, reset 0064h
// RL22 - Latched bits clear only on completed read; coincident event kept
//------------------------------------------------------------------
module annp_regs #(
    parameter logic STRAP_DEFAULT_EN = 1'b0 // Use strap pins at reset
) (
    input wire logic clk, // Core clock, 100 MHz
    input wire logic rst, // Sync reset, active high
    input wire logic ce, // Clock enable
    input wire annp_pkg::annp_mgmt_req_t req, // Management access
    output logic [15:0] rdata, // Read data, registered
    output logic rvalid, // Read data valid pulse
    input wire annp_pkg::annp_eng_t eng, // Negotiation engine status
    input wire logic strap_gig_fd, // Strap for full duplex offer
    input wire logic strap_gig_hd, // Strap for half duplex offer
    input wire logic tdr_busy, // Reflectometry running
    output logic tdr_start, // Reflectometry start pulse
    output logic [15:0] tx_page, // Next page to transmit
    output annp_pkg::annp_cfg_t cfg // Configuration to engine
);
    //--------------------------------------------------------------
    // State
    //--------------------------------------------------------------
    typedef struct packed {
        logic [15:0] nptx_r;
        logic [15:0] nprx_r;
        logic [15:0] cfg1_r;
        logic lp_np_r;
        logic lp_an_r;
        logic strap_done_r;
        logic [15:0] rdata_r;
        logic rvalid_r;
    } annp_regs_st_t;

    annp_regs_st_t st_r;
    annp_regs_st_t st_nxt;

    logic pdf_q;
    logic page_q;
    logic rd_exp;
    logic [15:0] exp_val;

    assign rd_exp = req.rd && (req.addr == annp_pkg::ANNP_OFF_EXP);

    //--------------------------------------------------------------
    // Latched status
    //--------------------------------------------------------------
    annp_latch u_pdf (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .set(eng.pd_fault), // RL3
        .clr(rd_exp), // RL3
        .q(pdf_q)
    );

    annp_latch u_page (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .set(eng.page_rx), // RL6
        .clr(rd_exp), // RL6
        .q(page_q)
    );

    annp_tdr_trig u_tdr (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .enable(st_r.cfg1_r[annp_pkg::ANNP_CFG_TDR]),
        .link_down(eng.link_down),
        .tdr_busy(tdr_busy),
        .tdr_start(tdr_start)
    );

    //--------------------------------------------------------------
    // Expansion status assembly
    //--------------------------------------------------------------
    always_comb begin
        exp_val = '0;
        exp_val[annp_pkg::ANNP_EXP_LOC_DEF] = 1'b1; // RL1
        exp_val[annp_pkg::ANNP_EXP_STORE] = 1'b1; // RL2
        exp_val[annp_pkg::ANNP_EXP_PDF] = pdf_q; // RL3
        exp_val[annp_pkg::ANNP_EXP_LP_NP] = st_r.lp_np_r; // RL4
        exp_val[annp_pkg::ANNP_EXP_LOC_NP] = 1'b1; // RL5
        exp_val[annp_pkg::ANNP_EXP_PAGE] = page_q; // RL6
        exp_val[annp_pkg::ANNP_EXP_LP_AN] = st_r.lp_an_r; // RL7
    end

    //--------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid_r = 1'b0;
        st_nxt.lp_np_r = eng.partner_np_capable; // RL4
        st_nxt.lp_an_r = eng.lp_an_able; // RL7

        // Straps caught once after reset release, never under reset
        if (!st_r.strap_done_r) begin
            st_nxt.strap_done_r = 1'b1;
            if (STRAP_DEFAULT_EN) begin
                st_nxt.cfg1_r[annp_pkg::ANNP_CFG_GFD] = strap_gig_fd; // RL19
                st_nxt.cfg1_r[annp_pkg::ANNP_CFG_GHD] = strap_gig_hd; // RL19
            end
        end

        // Toggle seeds on restart; flipped here on each engine page_tx
        if (eng.an_restart) begin
            st_nxt.nptx_r[annp_pkg::ANNP_NP_TOG] = !eng.adv_toggle; // RL11
            st_nxt.nprx_r[annp_pkg::ANNP_NP_TOG] =
                !eng.lp_base_toggle; // RL15
        end else if (eng.page_tx) begin
            st_nxt.nptx_r[annp_pkg::ANNP_NP_TOG] =
                !st_r.nptx_r[annp_pkg::ANNP_NP_TOG]; // RL11
        end

        // Partner page captured whole; bit 11 follows partner
        if (eng.page_rx) begin
            st_nxt.nprx_r = eng.rx_page; // RL13 RL14 RL15
        end

        // Register writes; read-only bits masked out
        if (req.wr) begin
            if (req.addr == annp_pkg::ANNP_OFF_NPTX) begin
                st_nxt.nptx_r = (req.wdata & annp_pkg::ANNP_NPTX_WMASK) |
                    (st_nxt.nptx_r & ~annp_pkg::ANNP_NPTX_WMASK); // RL8 RL9
            end else if (req.addr == annp_pkg::ANNP_OFF_CFG1) begin
                st_nxt.cfg1_r = req.wdata & annp_pkg::ANNP_CFG1_WMASK;
            end
        end

        // Registered read return; unmapped offsets read zero
        if (req.rd) begin
            st_nxt.rvalid_r = 1'b1;
            if (req.addr == annp_pkg::ANNP_OFF_EXP) begin
                st_nxt.rdata_r = exp_val; // RL21
            end else if (req.addr == annp_pkg::ANNP_OFF_NPTX) begin
                st_nxt.rdata_r = st_r.nptx_r;
            end else if (req.addr == annp_pkg::ANNP_OFF_NPRX) begin
                st_nxt.rdata_r = st_r.nprx_r; // RL13
            end else if (req.addr == annp_pkg::ANNP_OFF_CFG1) begin
                st_nxt.rdata_r = st_r.cfg1_r;
            end else begin
                st_nxt.rdata_r = '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r.nptx_r <= annp_pkg::ANNP_RST_NPTX; // RL9 RL12
            st_r.nprx_r <= annp_pkg::ANNP_RST_NPRX;
            st_r.cfg1_r <= annp_pkg::ANNP_RST_CFG1; // RL19
            st_r.lp_np_r <= 1'b0;
            st_r.lp_an_r <= 1'b0;
            st_r.strap_done_r <= 1'b0;
            st_r.rdata_r <= '0;
            st_r.rvalid_r <= 1'b0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    //--------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------
    assign rdata = st_r.rdata_r;
    assign rvalid = st_r.rvalid_r;
    assign tx_page = st_r.nptx_r; // RL8 RL10 RL12

    always_comb begin
        cfg.test_mode = annp_pkg::annp_test_mode_t'(
            st_r.cfg1_r[annp_pkg::ANNP_CFG_TM_LO +: 3]); // RL16
        cfg.role_force_enable =
            st_r.cfg1_r[annp_pkg::ANNP_CFG_RF_EN]; // RL17
        cfg.role_force_value =
            st_r.cfg1_r[annp_pkg::ANNP_CFG_RF_VAL]; // RL17
        cfg.multi_port = st_r.cfg1_r[annp_pkg::ANNP_CFG_PORT]; // RL18
        cfg.gig_full_duplex_offer = st_r.cfg1_r[annp_pkg::ANNP_CFG_GFD];
        cfg.gig_half_duplex_offer = st_r.cfg1_r[annp_pkg::ANNP_CFG_GHD];
        cfg.reflectometry_on_link_loss =
            st_r.cfg1_r[annp_pkg::ANNP_CFG_TDR]; // RL20
    end
endmodule

`default_nettype wire

// ===== verification/annp_regs_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module annp_regs_chk (
    input wire logic clk, // Core clock
    input wire logic rst, // Sync reset
    input wire logic ce, // Clock enable
    input wire annp_pkg::annp_mgmt_req_t req, // Management access
    input wire logic [15:0] rdata, // Read data
    input wire logic rvalid, // Read valid
    input wire annp_pkg::annp_eng_t eng, // Engine status
    input wire logic tdr_busy, // Reflectometry busy
    input wire logic tdr_start, // Reflectometry start
    input wire logic [15:0] tx_page, // Page to send
    input wire annp_pkg::annp_cfg_t cfg // Configuration
);
    // ----------------------------------------------------------
    // Properties
    // ----------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_rd(logic [4:0] a);
        ce && req.rd && req.addr == a;
    endsequence
    sequence s_wr(logic [4:0] a);
        ce && req.wr && req.addr == a;
    endsequence
    a_exp_fixed_bits: assert property (s_rd(5'h06) |=> rvalid &&
        rdata[15:7] == 9'h0 && rdata[6:5] == 2'b11 && rdata[2])
        else $error("fixed status bits");
    a_no_stray_rvalid: assert property (ce && !req.rd |=> !rvalid)
        else $error("stray rvalid");
    a_unmapped_zero: assert property (ce && req.rd &&
        (req.addr < 5'h06 || req.addr > 5'h09) |=> rdata == 16'h0000)
        else $error("unmapped read");
    a_tx_write: assert property (s_wr(5'h07) |=>
        (tx_page & 16'hb7ff) == ($past(req.wdata) & 16'hb7ff))
        else $error("page write");
    a_tx_toggle: assert property (ce && eng.page_tx &&
        !eng.an_restart |=> tx_page[11] != $past(tx_page[11]))
        else $error("toggle flip");
    a_toggle_seed: assert property (ce && eng.an_restart |=>
        tx_page[11] == !$past(eng.adv_toggle))
        else $error("toggle seed");
    a_cfg_write: assert property (s_wr(5'h09) |=>
        cfg == $past(req.wdata[15:7]))
        else $error("config write");
    a_page_latched: assert property (ce && eng.page_rx ##1
        ce && !req.rd ##1 s_rd(5'h06) |=> rdata[1])
        else $error("page flag");
    a_fault_kept: assert property (ce && eng.pd_fault &&
        req.rd && req.addr == 5'h06 ##1 ce && !req.rd ##1 s_rd(5'h06)
        |=> rdata[4])
        else $error("fault kept");
    a_rx_load: assert property (ce && eng.page_rx ##1
        ce && !eng.page_rx ##1 s_rd(5'h08)
        |=> rdata == $past(eng.rx_page, 3))
        else $error("received page");
    a_partner_able: assert property (s_rd(5'h06) && !$past(rst)
        |=> rdata[3] == $past(eng.partner_np_capable, 2) &&
        rdata[0] == $past(eng.lp_an_able, 2))
        else $error("partner ability");
    a_tdr_start: assert property (ce && eng.link_down && !tdr_busy
        && cfg.reflectometry_on_link_loss ##1 ce && !tdr_busy
        && cfg.reflectometry_on_link_loss |=> tdr_start)
        else $error("auto run missing");
    a_tdr_gated: assert property (tdr_start |->
        $past(cfg.reflectometry_on_link_loss))
        else $error("auto run disabled");
endmodule
`default_nettype wire

// ===== verification/annp_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module annp_link_partner (
    input wire logic clk, // Core clock
    output var annp_pkg::annp_eng_t eng // Engine status
);
    initial begin
        eng = '0;
        eng.adv_toggle = 1'b1;
        eng.lp_base_toggle = 1'b1;
        eng.rx_page = 16'hffff;
    end
    // One-cycle event, raised between edges
    task automatic ev(input int k, input logic [15:0] w);
        @(negedge clk);
        eng.rx_page = w;
        case (k)
            0: eng.page_rx = 1'b1;
            1: eng.pd_fault = 1'b1;
            2: eng.page_tx = 1'b1;
            3: eng.an_restart = 1'b1;
            default: eng.link_down = 1'b1;
        endcase
        @(negedge clk);
        {eng.page_rx, eng.pd_fault, eng.page_tx} = 3'h0;
        {eng.an_restart, eng.link_down} = 2'h0;
        // Word is not held past its strobe
        eng.rx_page = ~w;
    endtask
    task automatic lvl(input logic np, input logic an);
        @(negedge clk);
        eng.partner_np_capable = np;
        eng.lp_an_able = an;
    endtask
endmodule
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tdr_busy = 1'b0;
    annp_pkg::annp_mgmt_req_t req = '0;
    annp_pkg::annp_eng_t eng;
    annp_pkg::annp_cfg_t cfg;
    annp_pkg::annp_cfg_t cfg_s;
    logic [15:0] rdata;
    logic [15:0] tx_page;
    logic [15:0] v;
    logic rvalid;
    logic tdr_start;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    annp_link_partner u_lp (.clk(clk), .eng(eng));
    annp_regs dut (.clk(clk), .rst(rst), .ce(1'b1), .req(req),
        .rdata(rdata), .rvalid(rvalid), .eng(eng), .strap_gig_fd(1'b0),
        .strap_gig_hd(1'b0), .tdr_busy(tdr_busy), .tdr_start(tdr_start),
        .tx_page(tx_page), .cfg(cfg));
    // Strap path only; bus and engine shared with dut
    annp_regs #(.STRAP_DEFAULT_EN(1'b1)) dut_strap (.clk(clk), .rst(rst),
        .ce(1'b1), .req(req), .rdata(), .rvalid(), .eng(eng),
        .strap_gig_fd(1'b0), .strap_gig_hd(1'b1), .tdr_busy(tdr_busy),
        .tdr_start(), .tx_page(), .cfg(cfg_s));
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req.wr = 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(negedge clk);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clk);
        req.rd = 1'b0;
        chk("rvalid", 16'h0001, {15'h0, rvalid});
        chk("rdata", e, rdata);
    endtask
    task automatic see_start(input logic e);
        logic hit;
        hit = 1'b0;
        repeat (5) begin
            @(negedge clk);
            hit = hit | tdr_start;
        end
        chk("tdr_start", {15'h0, e}, {15'h0, hit});
    endtask
    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_reset();
        rd(5'h06, 16'h0064);
        chk("strap cfg", 16'h0002, {7'h0, cfg_s});
        rd(5'h07, 16'h2001);
        rd(5'h08, 16'h2001);
        rd(5'h09, 16'h0300);
        rd(5'h1f, 16'h0000);
        wr(5'h06, 16'hffff);
        rd(5'h06, 16'h0064);
    endtask
    task automatic t_tx();
        wr(5'h07, 16'hffff);
        rd(5'h07, 16'hb7ff);
        wr(5'h07, 16'h4800);
        rd(5'h07, 16'h0000);
        u_lp.ev(2, 16'h0000);
        rd(5'h07, 16'h0800);
        chk("tx_page", 16'h0800, tx_page);
        u_lp.ev(3, 16'h0000);
        rd(5'h07, 16'h0000);
    endtask
    task automatic t_rx();
        u_lp.ev(0, 16'hd5a5);
        rd(5'h08, 16'hd5a5);
        rd(5'h06, 16'h0066);
        rd(5'h06, 16'h0064);
        u_lp.ev(0, 16'h2a5a);
        rd(5'h06, 16'h0066);
        wr(5'h08, 16'h0000);
        rd(5'h08, 16'h2a5a);
    endtask
    task automatic t_status();
        fork
            u_lp.ev(1, 16'h0000);
            rd(5'h06, 16'h0064);
        join
        rd(5'h06, 16'h0074);
        rd(5'h06, 16'h0064);
        u_lp.lvl(1'b1, 1'b1);
        rd(5'h06, 16'h006d);
        u_lp.lvl(1'b0, 1'b0);
    endtask
    task automatic t_cfg();
        for (int m = 0; m < 8; m++) begin
            v = {m[2:0], m[0], m[1], m[2], m[1], m[0], ~m[0], 7'h7f};
            wr(5'h09, v);
            chk("cfg", {7'h0, v[15:7]}, {7'h0, cfg});
            rd(5'h09, v & 16'hff80);
        end
    endtask
    task automatic t_tdr();
        wr(5'h09, 16'h0380);
        u_lp.ev(4, 16'h0000);
        see_start(1'b1);
        tdr_busy = 1'b1;
        u_lp.ev(4, 16'h0000);
        see_start(1'b0);
        tdr_busy = 1'b0;
        see_start(1'b1);
        wr(5'h09, 16'h0300);
        u_lp.ev(4, 16'h0000);
        see_start(1'b0);
    endtask
    // Ceiling far above the roughly 130 cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_status();
        t_tx();
        t_rx();
        t_cfg();
        t_tdr();
        final_report();
    end
endmodule
bind annp_regs annp_regs_chk u_chk (.clk(clk), .rst(rst), .ce(ce),
    .req(req), .rdata(rdata), .rvalid(rvalid), .eng(eng),
    .tdr_busy(tdr_busy), .tdr_start(tdr_start), .tx_page(tx_page),
    .cfg(cfg));
`default_nettype wire
